// ---- rtl/wot_map.svh ----
// register offsets, field positions, reset values and timing counts for the wait one-shot timer
`ifndef WOT_MAP_SVH
`define WOT_MAP_SVH

`define WOT_ADDR_W          4
`define WOT_OFF_MODE        4'h0
`define WOT_OFF_OS_CTRL     4'h1
`define WOT_OFF_PULSE_MODE  4'h2
`define WOT_OFF_PRESCALER   4'h3
`define WOT_OFF_PRIMARY     4'h4
`define WOT_OFF_SECONDARY   4'h5
`define WOT_OFF_STATUS      4'h6

// timer_mode_reg fields
`define WOT_MODE_SRC_LSB    0
`define WOT_MODE_RUN_BIT    7
// oneshot_control_reg fields
`define WOT_OSC_START_BIT   0
// pulse_output_mode_reg fields
`define WOT_PUM_POL_BIT     5
`define WOT_PUM_TRIG_EN_BIT 6
`define WOT_PUM_LEVEL_BIT   7
// status fields (write 1 to clear)
`define WOT_ST_TMR_IRQ_BIT  0
`define WOT_ST_EXT_IRQ_BIT  1

`define WOT_RST_BYTE        8'h00
`define WOT_RST_PERIOD      8'hff

// count source dividers
`define WOT_DIV2_CNT        1'h1
`define WOT_DIV8_CNT        3'h7

`endif

// ---- rtl/wot_pkg.sv ----
// types for the wait one-shot timer
package wot_pkg;
  typedef enum logic [1:0] {
    WOT_SRC_F1  = 2'b00,
    WOT_SRC_F2  = 2'b01,
    WOT_SRC_F8  = 2'b10,
    WOT_SRC_UFL = 2'b11
  } wot_src_t;

  typedef enum logic [1:0] {
    WOT_IDLE    = 2'b00,
    WOT_WAIT    = 2'b01,
    WOT_PULSE   = 2'b10,
    WOT_FINISH  = 2'b11
  } wot_state_t;

  typedef struct packed {
    wot_state_t state;
    logic [7:0] mode;
    logic       os_start;
    logic [7:0] pulse_output_mode_reg;
    logic [7:0] pre_rld;
    logic [7:0] pri_rld;
    logic [7:0] sec_rld;
    logic [7:0] pre_cnt;
    logic [7:0] pri_cnt;
    logic [2:0] div;
    logic       sync1;
    logic       sync2;
    logic       trig_d;
    logic       ufl1;
    logic       ufl2;
    logic       ufl_d;
    logic       tmr_irq;
    logic       ext_irq;
    logic       pulse_out;
    logic       irq;
    logic [7:0] rdata;
  } wot_state_s_t;
endpackage

// ---- rtl/wot_timer.sv ----
// wait one-shot timer: prescaler, primary wait counter and secondary pulse counter
`timescale 1ns/1ps
`default_nettype none
`include "wot_map.svh"

module wot_timer (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [`WOT_ADDR_W-1:0] addr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [7:0]            rdata,
  input  wire logic                  ext_trigger_pin,
  input  wire logic                  companion_ufl,
  output logic                       pulse_out_pin,
  output logic                       timer_irq,
  output logic                       ext_pin_irq
);

  wot_pkg::wot_state_s_t s_reg;
  wot_pkg::wot_state_s_t s_next;

  logic                  tick;
  logic                  pre_ufl;
  logic                  edge_act;
  logic                  count_run_flag;
  logic                  ext_trigger_enable;
  logic                  ext_trigger_polarity;
  logic                  output_level_select;
  logic                  stop_req;
  logic                  start_req;
  logic                  active;
  wot_pkg::wot_src_t     src;

  function automatic logic hit(input logic [`WOT_ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction

  // field views of the control registers
  assign count_run_flag       = s_reg.mode[`WOT_MODE_RUN_BIT];
  assign src                  = wot_pkg::wot_src_t'(s_reg.mode[`WOT_MODE_SRC_LSB +: 2]);
  assign ext_trigger_enable   = s_reg.pulse_output_mode_reg[`WOT_PUM_TRIG_EN_BIT];
  assign ext_trigger_polarity = s_reg.pulse_output_mode_reg[`WOT_PUM_POL_BIT];
  assign output_level_select  = s_reg.pulse_output_mode_reg[`WOT_PUM_LEVEL_BIT];
  assign active = (s_reg.state == wot_pkg::WOT_WAIT) || (s_reg.state == wot_pkg::WOT_PULSE);

  // count source select; the companion underflow is synchronised then edge detected
  always_comb begin
    case (src)
      wot_pkg::WOT_SRC_F1: tick = 1'b1;
      wot_pkg::WOT_SRC_F2: tick = (s_reg.div[0] == `WOT_DIV2_CNT);
      wot_pkg::WOT_SRC_F8: tick = (s_reg.div == `WOT_DIV8_CNT);
      default:             tick = s_reg.ufl2 && !s_reg.ufl_d;
    endcase
  end

  // prescaler underflow is the step of the main counter
  assign pre_ufl = tick && (s_reg.pre_cnt == 8'h00);

  // active edge seen on the synchronised trigger pin; polarity 1 picks rising
  assign edge_act = ext_trigger_polarity ? (s_reg.sync2 && !s_reg.trig_d)
                                         : (!s_reg.sync2 && s_reg.trig_d);

  // software stop: run flag cleared or start bit cleared while counting
  always_comb begin
    stop_req = 1'b0;
    if (wr && hit(`WOT_OFF_MODE) && !wdata[`WOT_MODE_RUN_BIT]) begin
      stop_req = 1'b1;
    end else if (wr && hit(`WOT_OFF_OS_CTRL) && !wdata[`WOT_OSC_START_BIT]) begin
      stop_req = 1'b1;
    end
  end

  // start by software write or by an enabled trigger edge, only when idle
  always_comb begin
    start_req = 1'b0;
    if (count_run_flag && (s_reg.state == wot_pkg::WOT_IDLE)) begin
      if (wr && hit(`WOT_OFF_OS_CTRL) && wdata[`WOT_OSC_START_BIT]) begin
        start_req = 1'b1;
      end else if (ext_trigger_enable && edge_act) begin
        start_req = 1'b1;
      end
    end
  end

  // whole next state of the block
  always_comb begin
    s_next        = s_reg;
    s_next.div    = s_reg.div + 3'h1;
    s_next.sync1  = ext_trigger_pin;
    s_next.sync2  = s_reg.sync1;
    s_next.trig_d = s_reg.sync2;
    s_next.ufl1   = companion_ufl;
    s_next.ufl2   = s_reg.ufl1;
    s_next.ufl_d  = s_reg.ufl2;
    s_next.rdata  = 8'h00;

    // register writes; period writes touch only the reload copies
    if (wr) begin
      if (hit(`WOT_OFF_MODE)) begin
        s_next.mode = wdata;
      end else if (hit(`WOT_OFF_OS_CTRL)) begin
        s_next.os_start = wdata[`WOT_OSC_START_BIT] && count_run_flag;
      end else if (hit(`WOT_OFF_PULSE_MODE)) begin
        s_next.pulse_output_mode_reg = wdata;
      end else if (hit(`WOT_OFF_PRESCALER)) begin
        s_next.pre_rld = wdata;
      end else if (hit(`WOT_OFF_PRIMARY)) begin
        s_next.pri_rld = wdata;
      end else if (hit(`WOT_OFF_SECONDARY)) begin
        s_next.sec_rld = wdata;
      end else if (hit(`WOT_OFF_STATUS)) begin
        if (wdata[`WOT_ST_TMR_IRQ_BIT]) begin
          s_next.tmr_irq = 1'b0;
        end
        if (wdata[`WOT_ST_EXT_IRQ_BIT]) begin
          s_next.ext_irq = 1'b0;
        end
      end
    end

    // pin interrupt follows any active edge, even mid-count or trigger disabled
    if (edge_act) begin
      s_next.ext_irq = 1'b1;
    end

    // sequencer
    case (s_reg.state)
      wot_pkg::WOT_IDLE: begin
        // at rest the counters track the reload copies
        s_next.pre_cnt = s_next.pre_rld;
        s_next.pri_cnt = s_next.pri_rld;
        if (start_req) begin
          s_next.state    = wot_pkg::WOT_WAIT;
          s_next.os_start = 1'b1;
          s_next.pre_cnt  = s_reg.pre_rld;
          s_next.pri_cnt  = s_reg.pri_rld;
        end
      end
      wot_pkg::WOT_WAIT: begin
        if (tick) begin
          s_next.pre_cnt = pre_ufl ? s_reg.pre_rld : s_reg.pre_cnt - 8'h01;
        end
        if (pre_ufl) begin
          if (s_reg.pri_cnt == 8'h00) begin
            s_next.pri_cnt   = s_reg.sec_rld;
            s_next.state     = wot_pkg::WOT_PULSE;
            s_next.pulse_out = 1'b1;
          end else begin
            s_next.pri_cnt = s_reg.pri_cnt - 8'h01;
          end
        end
      end
      wot_pkg::WOT_PULSE: begin
        if (tick) begin
          s_next.pre_cnt = pre_ufl ? s_reg.pre_rld : s_reg.pre_cnt - 8'h01;
        end
        if (pre_ufl && (s_reg.pri_cnt == 8'h00)) begin
          s_next.pri_cnt  = s_reg.pri_rld;
          s_next.pre_cnt  = s_reg.pre_rld;
          s_next.state    = wot_pkg::WOT_FINISH;
        end else if (pre_ufl) begin
          s_next.pri_cnt = s_reg.pri_cnt - 8'h01;
        end
      end
      default: begin
        // reload done: pulse ends as the interrupt rises, start bit clears
        s_next.state     = wot_pkg::WOT_IDLE;
        s_next.os_start  = 1'b0;
        s_next.pulse_out = 1'b0;
        s_next.tmr_irq   = 1'b1;
      end
    endcase

    // software stop wins over counting: reload then rest
    if (active && stop_req) begin
      s_next.state     = wot_pkg::WOT_IDLE;
      s_next.pre_cnt   = s_reg.pre_rld;
      s_next.pri_cnt   = s_reg.pri_rld;
      s_next.pulse_out = 1'b0;
      s_next.os_start  = 1'b0;
    end

    // interrupt line: copy of the timer flag; the level bit does not touch it
    s_next.irq = s_next.tmr_irq;

    // read data one cycle later; prescaler shows its live count, primary and secondary show theirs only in their own phase
    if (rd) begin
      if (hit(`WOT_OFF_MODE)) begin
        s_next.rdata = s_reg.mode;
      end else if (hit(`WOT_OFF_OS_CTRL)) begin
        s_next.rdata = {7'h00, s_reg.os_start};
      end else if (hit(`WOT_OFF_PULSE_MODE)) begin
        s_next.rdata = s_reg.pulse_output_mode_reg;
      end else if (hit(`WOT_OFF_PRESCALER)) begin
        s_next.rdata = s_reg.pre_cnt;
      end else if (hit(`WOT_OFF_PRIMARY)) begin
        s_next.rdata = (s_reg.state == wot_pkg::WOT_PULSE) ? s_reg.pri_rld
                                                           : s_reg.pri_cnt;
      end else if (hit(`WOT_OFF_SECONDARY)) begin
        s_next.rdata = (s_reg.state == wot_pkg::WOT_PULSE) ? s_reg.pri_cnt
                                                           : s_reg.sec_rld;
      end else if (hit(`WOT_OFF_STATUS)) begin
        s_next.rdata = {4'h0, s_reg.state, s_reg.ext_irq, s_reg.tmr_irq};
      end
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg         <= '0;
      s_reg.state   <= wot_pkg::WOT_IDLE;
      s_reg.mode    <= `WOT_RST_BYTE;
      s_reg.pulse_output_mode_reg     <= `WOT_RST_BYTE;
      s_reg.pre_rld <= `WOT_RST_PERIOD;
      s_reg.pri_rld <= `WOT_RST_PERIOD;
      s_reg.sec_rld <= `WOT_RST_PERIOD;
      s_reg.pre_cnt <= `WOT_RST_PERIOD;
      s_reg.pri_cnt <= `WOT_RST_PERIOD;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flip-flops; xor with level select kept in a flop copy
  logic pin_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= s_next.pulse_out ^ s_next.pulse_output_mode_reg[`WOT_PUM_LEVEL_BIT];
    end
  end

  assign pulse_out_pin = pin_reg;
  assign timer_irq     = s_reg.irq;
  assign ext_pin_irq   = s_reg.ext_irq;
  assign rdata         = s_reg.rdata;

  // output_level_select is read by nothing; the pin above uses the next-state level bit
  logic unused_level;
  assign unused_level = output_level_select;

endmodule
`default_nettype wire

// ---- verif/wot_timer_properties.sv ----
// port-level assertions for the wait one-shot timer
`timescale 1ns/1ps
`default_nettype none
`include "wot_map.svh"
module wot_timer_properties (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic [`WOT_ADDR_W-1:0] addr,
  input wire logic [7:0]             wdata,
  input wire logic                   wr,
  input wire logic                   rd,
  input wire logic [7:0]             rdata,
  input wire logic                   ext_trigger_pin,
  input wire logic                   companion_ufl,
  input wire logic                   pulse_out_pin,
  input wire logic                   timer_irq,
  input wire logic                   ext_pin_irq
);
  logic       run_reg;
  logic       lvl_reg;
  logic [2:0] quiet_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // mirror run and level bits; quiet counts cycles since either was written
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_reg   <= 1'b0;
      lvl_reg   <= 1'b0;
      quiet_reg <= 3'h7;
    end else begin
      if (wr && addr == `WOT_OFF_MODE) run_reg <= wdata[`WOT_MODE_RUN_BIT];
      if (wr && addr == `WOT_OFF_PULSE_MODE) lvl_reg <= wdata[`WOT_PUM_LEVEL_BIT];
      if (wr && (addr == `WOT_OFF_MODE || addr == `WOT_OFF_PULSE_MODE)) quiet_reg <= 3'h0;
      else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
    end
  end
  sequence s_start_write;
    wr && addr == `WOT_OFF_OS_CTRL && wdata[`WOT_OSC_START_BIT];
  endsequence
  // pulse held at least two cycles, then the pin moves as the interrupt rises
  sequence s_pulse_tail;
    $past(pulse_out_pin) == $past(pulse_out_pin, 2) ##0 $changed(pulse_out_pin);
  endsequence
  a_rdata_quiet: assert property (!$past(rd) || $past(addr) > `WOT_OFF_STATUS |-> rdata == 8'h00)
    else $error("read data not zero outside a mapped read");
  a_status_read: assert property ($past(rd && addr == `WOT_OFF_STATUS) |->
    rdata[0] == $past(timer_irq) && rdata[1] == $past(ext_pin_irq))
    else $error("status read disagrees with interrupt outputs");
  a_timer_irq_clear: assert property ($fell(timer_irq) |->
    $past(wr && addr == `WOT_OFF_STATUS && wdata[`WOT_ST_TMR_IRQ_BIT]))
    else $error("timer interrupt dropped without a clear");
  a_ext_irq_clear: assert property ($fell(ext_pin_irq) |->
    $past(wr && addr == `WOT_OFF_STATUS && wdata[`WOT_ST_EXT_IRQ_BIT]))
    else $error("pin interrupt dropped without a clear");
  a_irq_pulse_end: assert property ($rose(timer_irq) |-> s_pulse_tail)
    else $error("timer interrupt not at end of pulse");
  a_ext_irq_cause: assert property ($rose(ext_pin_irq) |->
    $past(ext_trigger_pin, 3) != $past(ext_trigger_pin, 4))
    else $error("pin interrupt without a pin edge");
  a_refused_start: assert property (s_start_write ##0 !run_reg && quiet_reg == 3'h7
    |=> $stable(pulse_out_pin) [*2])
    else $error("start accepted with run flag clear");
  a_stopped_rest: assert property (!run_reg && quiet_reg == 3'h3 |-> pulse_out_pin == lvl_reg)
    else $error("stopped pin not at idle level");
endmodule

bind wot_timer wot_timer_properties u_props (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .ext_trigger_pin(ext_trigger_pin), .companion_ufl(companion_ufl),
  .pulse_out_pin(pulse_out_pin), .timer_irq(timer_irq), .ext_pin_irq(ext_pin_irq));
`default_nettype wire

// ---- verif/wot_far_end.sv ----
// far side model: trigger source on the external pin and companion underflow ticks
`timescale 1ns/1ps
`default_nettype none
module wot_far_end (
  input  wire logic clk,
  input  wire logic fire,
  input  wire logic pol,
  output logic      trig_pin,
  output logic      ufl
);
  logic [2:0] hold_reg = 3'h0;
  logic [1:0] phase_reg = 2'h0;
  // active level shown four cycles, wide enough for the two-flop synchroniser
  always @(posedge clk) begin
    phase_reg <= phase_reg + 2'h1;
    if (fire) hold_reg <= 3'h4;
    else if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
  end
  assign trig_pin = (hold_reg != 3'h0) ? pol : ~pol;
  // companion underflow high two cycles of four, never a one-cycle blip
  assign ufl = phase_reg[1];
endmodule
`default_nettype wire

// ---- verif/tb_wait_oneshot_timer.sv ----
// self-checking bench for the wait one-shot timer
`timescale 1ns/1ps
`default_nettype none
`include "wot_map.svh"
module tb_wait_oneshot_timer;
  logic        clk, rst_n, wr, rd, fire, pol, trig, ufl, pin, tirq, eirq;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [31:0] seed;
  int          failures, comparisons;
  int          dv [4] = '{1, 2, 8, 4};
  wot_timer dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_trigger_pin(trig), .companion_ufl(ufl), .pulse_out_pin(pin),
    .timer_irq(tirq), .ext_pin_irq(eirq));
  wot_far_end far (.clk(clk), .fire(fire), .pol(pol), .trig_pin(trig), .ufl(ufl));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int span(input int n, input int k, input int d);
    return (n + 1) * (k + 1) * d;
  endfunction
  // source phase is unknown, so allow one source period either way, plus two more cycles on the late side
  function automatic logic near(input int seen, input int exp, input int d);
    return seen >= exp - d && seen <= exp + d + 2;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    // one idle cycle so the strobe is never lowered and raised in one time step
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // data is read at the second edge, before that edge's update lands
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic shot(input int w, input int p, input int d, input logic lvl);
    int n;
    n = 1;
    while (pin === lvl && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (w > 0) check(near(n, w, d), 1'b1);
    n = 0;
    while (pin !== lvl && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check(near(n, p, d), 1'b1);
    check(tirq, 1'b1);
  endtask
  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin : watchdog
    repeat (40000) @(posedge clk);
    failures++;
    complete_run();
  end
  initial begin : main_seq
    logic [7:0] v;
    logic       lvl;
    int         pre, pri, nxt, sec, src;
    {rst_n, wr, rd, fire, pol} = 5'h00;
    addr = 4'h0;
    wdata = 8'h00;
    seed = 32'hb618;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rreg(`WOT_OFF_MODE, v);
    check(v, `WOT_RST_BYTE);
    rreg(`WOT_OFF_PRIMARY, v);
    check(v, `WOT_RST_PERIOD);
    $display("test reset done");
    pri = 3;
    wreg(`WOT_OFF_PRIMARY, 8'(pri));
    for (int i = 0; i < 8; i++) begin
      seed = step(seed);
      lvl = seed[8];
      nxt = int'(seed[7:5]);
      sec = int'(seed[4:2]);
      pre = int'(seed[1:0]);
      src = i % 4;
      wreg(`WOT_OFF_MODE, 8'h80 | 8'(src));
      wreg(`WOT_OFF_PULSE_MODE, {lvl, 7'h00});
      wreg(`WOT_OFF_PRESCALER, 8'(pre));
      wreg(`WOT_OFF_SECONDARY, 8'(sec));
      wreg(`WOT_OFF_OS_CTRL, 8'h01);
      wreg(`WOT_OFF_OS_CTRL, 8'h00); // aborted at once, counters reload
      repeat (4) @(posedge clk);
      check(pin, lvl);
      rreg(`WOT_OFF_PRIMARY, v);
      check(v, 8'(pri));
      wreg(`WOT_OFF_OS_CTRL, 8'h01);
      wreg(`WOT_OFF_PRIMARY, 8'(nxt)); // the wait in flight keeps the old period
      shot(span(pre, pri, dv[src]), span(pre, sec, dv[src]), dv[src], lvl);
      rreg(`WOT_OFF_STATUS, v);
      check(v[0], 1'b1);
      rreg(`WOT_OFF_OS_CTRL, v);
      check(v[0], 1'b0);
      rreg(`WOT_OFF_PRIMARY, v);
      check(v, 8'(nxt));
      wreg(`WOT_OFF_STATUS, 8'h03);
      repeat (2) @(posedge clk);
      check(tirq, 1'b0);
      pri = nxt;
    end
    $display("test program shots done");
    wreg(`WOT_OFF_MODE, 8'h00);
    wreg(`WOT_OFF_PULSE_MODE, 8'h00);
    repeat (8) @(posedge clk);
    wreg(`WOT_OFF_OS_CTRL, 8'h01);
    repeat (40) @(posedge clk);
    check(pin, 1'b0);
    rreg(`WOT_OFF_OS_CTRL, v);
    check(v[0], 1'b0);
    $display("test refused start done");
    wreg(`WOT_OFF_MODE, 8'h80);
    wreg(`WOT_OFF_PRESCALER, 8'h00);
    wreg(`WOT_OFF_PRIMARY, 8'h07);
    wreg(`WOT_OFF_SECONDARY, 8'h03);
    wreg(`WOT_OFF_OS_CTRL, 8'h01);
    wreg(`WOT_OFF_OS_CTRL, 8'h00);
    for (int p = 0; p < 3; p++) begin
      pol <= p[0];
      wreg(`WOT_OFF_PULSE_MODE, {1'b0, p < 2, p[0], 5'h00});
      repeat (10) @(posedge clk);
      wreg(`WOT_OFF_STATUS, 8'h03);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (7) @(posedge clk);
      fire <= 1'b1; // second edge lands while counting when the trigger is enabled
      @(posedge clk);
      fire <= 1'b0;
      if (p < 2) shot(0, 4, 1, 1'b0);
      repeat (30) @(posedge clk);
      check(pin, 1'b0);
      check(eirq, 1'b1);
    end
    $display("test trigger done");
    complete_run();
  end
endmodule
`default_nettype wire
